// ---- floppy_lock_and_pin_tristate.sv ----
/*
 floppy controller parameter lock, result bytes and hot-swap pin
 tri-state control behind an apb register slave.
 assumes the controller core drives the pin values in and reports its
 automatic power-down conditions; inputs are synchronous to clk_sys.
*/
// The APB register port and the register addresses were chosen for this implementation.
// Functional notes
// - with the lock flag set, a software reset keeps fifo enable, fifo threshold and precompensation track.
// - a hardware reset clears the lock flag and returns those three parameters to their defaults.
// - a lock command returns one result byte that shows the lock value it carried.
// - the dump command puts the lock flag and per-drive perpendicular bits in its eighth byte.
// - after a hardware reset the block runs in one of three legacy modes chosen by identity and modulation bits.
// - the floppy outputs float whenever the floppy device is powered down or not activated.
// - mode register bit 7 floats the standard pins and leaves the parallel-port pins alone.
// - both pin groups float when inactive, powered down or the base is invalid; otherwise standard follow bit 7, parallel drive.
// - a base address outside 0x100 to 0x0ff8 floats the floppy outputs.
// - floppy power bit 0 of global register 0x22 at 0 counts as powered off and floats the outputs.
// - manual power-down bit 6 of the data-rate register floats the outputs and overrides auto power-down.
// - with auto power management on, outputs float only when all auto power-down conditions hold.
// - the tri-state covers write data, density, head, write gate, direction, step, both selects and motors.
// - a software reset clears only the gap and write-gate bits; a hardware reset clears all perpendicular bits.
`timescale 1ns/1ps
module floppy_lock_and_pin_tristate
	import fdc_lock_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire floppy_pins_s core_pins,
	input wire floppy_pins_s pp_core_pins,
	input wire logic [3:0] auto_pd_conds,
	output floppy_pins_s std_pins_o,
	output floppy_pins_s std_pins_oe_n,
	output floppy_pins_s pp_pins_o,
	output floppy_pins_s pp_pins_oe_n,
	output compat_mode_e compat_mode
);
	logic activate_r;
	logic [15:0] base_r;
	logic [31:0] global_r;
	logic [7:0] mode_r;
	logic pwrdn_r;
	logic lock_r;
	lock_params_s params_r;
	perp_s perp_r;
	logic acc, wr, rd, mapped, soft_rst;
	logic cmd_wr;
	logic [2:0] cmd_op;
	logic base_ok, powered, auto_pd, in_power_down, dev_on, std_drive, pp_drive;
	logic res_load, res_valid;
	logic [3:0] res_len, res_idx;
	logic [7:0] res_byte;
	logic [DUMP_LEN*8-1:0] res_bytes;

	// ---------------------------------------------------------------
	// apb decode
	// ---------------------------------------------------------------
	assign acc = psel && penable;
	assign wr = acc && pwrite && mapped;
	assign rd = acc && !pwrite && mapped;
	assign pready = 1'b1;
	assign pslverr = acc && !mapped;
	assign cmd_wr = wr && (paddr == OFS_COMMAND);
	assign cmd_op = pwdata[2:0];

	always_comb begin
		case (paddr)
			OFS_ACTIVATE, OFS_BASE, OFS_GLOBAL, OFS_MODE, OFS_DATA_RATE,
			OFS_DIGITAL_OUT, OFS_COMMAND, OFS_RESULT, OFS_STATUS, OFS_PARAMS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// software reset through either the digital output or data-rate register
	assign soft_rst = wr && (((paddr == OFS_DIGITAL_OUT) && !pwdata[DO_RESET_N_BIT])
		|| ((paddr == OFS_DATA_RATE) && pwdata[DR_SWRST_BIT]));

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			activate_r <= RST_ACTIVATE;
			base_r <= RST_BASE;
			global_r <= RST_GLOBAL;
			mode_r <= RST_MODE;
		end else if (wr) begin
			case (paddr)
				OFS_ACTIVATE: activate_r <= pwdata[ACT_BIT];
				OFS_BASE: base_r <= pwdata[15:0];
				OFS_GLOBAL: global_r <= pwdata;
				OFS_MODE: mode_r <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pwrdn_r <= RST_PWRDN;
		end else if (wr && (paddr == OFS_DATA_RATE)) begin
			pwrdn_r <= pwdata[DR_PWRDN_BIT];
		end
	end

	// identity bit picks the first mode, modulation bit splits the other two
	always_comb begin
		if (global_r[GLB_IDENT_BIT]) begin
			compat_mode = COMPAT_MODE_A;
		end else if (global_r[GLB_MODSEL_BIT]) begin
			compat_mode = COMPAT_MODE_B;
		end else begin
			compat_mode = COMPAT_MODE_C;
		end
	end

	// ---------------------------------------------------------------
	// lock flag, locked parameters and perpendicular bits
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lock_r <= RST_LOCK;
		end else if (cmd_wr && (cmd_op == CMD_LOCK)) begin
			lock_r <= pwdata[CMD_LOCK_BIT];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			params_r <= RST_PARAMS;
		end else if (soft_rst && !lock_r) begin
			params_r <= RST_PARAMS;
		end else if (cmd_wr && (cmd_op == CMD_CONFIGURE)) begin
			params_r.fifo_enable_param <= pwdata[CMD_FIFO_EN_BIT];
			params_r.fifo_threshold_param <= pwdata[CMD_THR_LSB +: 4];
			params_r.precomp_start_track <= pwdata[CMD_PRECOMP_START_TRACK_LSB +: 8];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			perp_r <= RST_PERP;
		end else if (soft_rst) begin
			perp_r.gap <= 1'b0;
			perp_r.perp_write_gate_bit <= 1'b0;
		end else if (cmd_wr && (cmd_op == CMD_PERP)) begin
			perp_r.gap <= pwdata[CMD_GAP_BIT];
			perp_r.perp_write_gate_bit <= pwdata[CMD_PERP_WRITE_GATE_BIT_BIT];
			// per-drive bits only move when the overwrite bit is set
			if (pwdata[CMD_OW_BIT]) begin
				perp_r.drive_perp <= pwdata[CMD_DRV_LSB +: 4];
			end
		end
	end

	// ---------------------------------------------------------------
	// result bytes
	// ---------------------------------------------------------------
	assign res_load = cmd_wr && ((cmd_op == CMD_LOCK) || (cmd_op == CMD_DUMP));
	assign res_len = (cmd_op == CMD_LOCK) ? LOCK_LEN_W : DUMP_LEN_W;

	always_comb begin
		res_bytes = '0;
		if (cmd_op == CMD_LOCK) begin
			res_bytes[LOCK_RES_BIT] = pwdata[CMD_LOCK_BIT];
		end else begin
			res_bytes[DUMP_LOCK_IDX*8 +: 8] = {lock_r, 1'b0, perp_r};
			res_bytes[DUMP_CFG_IDX*8 +: 8] = {2'b00, params_r.fifo_enable_param, 1'b0,
				params_r.fifo_threshold_param};
			res_bytes[DUMP_PRECOMP_START_TRACK_IDX*8 +: 8] = params_r.precomp_start_track;
		end
	end

	result_seq u_result (
		.clk_sys(clk_sys),
		.rst(rst),
		.flush(soft_rst),
		.load(res_load),
		.len(res_len),
		.bytes_in(res_bytes),
		.pop(rd && (paddr == OFS_RESULT)),
		.byte_o(res_byte),
		.idx(res_idx),
		.valid(res_valid)
	);

	// ---------------------------------------------------------------
	// read mux
	// ---------------------------------------------------------------
	always_comb begin
		prdata = 32'h0000_0000;
		if (rd) begin
			case (paddr)
				OFS_ACTIVATE: prdata[ACT_BIT] = activate_r;
				OFS_BASE: prdata[15:0] = base_r;
				OFS_GLOBAL: prdata = global_r;
				OFS_MODE: prdata[7:0] = mode_r;
				OFS_DATA_RATE: prdata[DR_PWRDN_BIT] = pwrdn_r;
				OFS_RESULT: prdata[8:0] = {res_valid, res_byte};
				OFS_STATUS: prdata[10:0] = {compat_mode, 2'b00, std_drive, pp_drive, base_ok,
					powered, auto_pd, lock_r};
				OFS_PARAMS: prdata[18:0] = {perp_r, params_r};
				default: prdata = 32'h0000_0000;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// pin enables
	// ---------------------------------------------------------------
	assign base_ok = (base_r >= BASE_MIN) && (base_r <= BASE_MAX);
	assign powered = global_r[GLB_POWER_BIT];
	// auto power-down only counts when every condition holds
	assign auto_pd = global_r[GLB_AUTOPM_BIT] && (&auto_pd_conds);
	// manual power-down wins whatever auto management says
	assign in_power_down = !powered || pwrdn_r || auto_pd;
	assign dev_on = activate_r && base_ok && !in_power_down;
	assign std_drive = dev_on && !mode_r[MODE_OUTCTL_BIT];
	assign pp_drive = dev_on;

	pin_gate #(.W(PIN_W)) u_std_pins (
		.clk_sys(clk_sys),
		.rst(rst),
		.din(core_pins),
		.drive(std_drive),
		.dout(std_pins_o),
		.oe_n(std_pins_oe_n)
	);

	pin_gate #(.W(PIN_W)) u_pp_pins (
		.clk_sys(clk_sys),
		.rst(rst),
		.din(pp_core_pins),
		.drive(pp_drive),
		.dout(pp_pins_o),
		.oe_n(pp_pins_oe_n)
	);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_soft_keeps_locked;
		soft_rst && lock_r |=> params_r == $past(params_r);
	endproperty
	a_soft_keeps_locked: assert property (p_soft_keeps_locked) else $error("locked params changed");

	property p_soft_clears_unlocked;
		soft_rst && !lock_r |=> params_r == RST_PARAMS;
	endproperty
	a_soft_clears_unlocked: assert property (p_soft_clears_unlocked) else $error("unlocked params kept");

	// the default disable would void every attempt, since its antecedent is the reset itself
	property p_hw_reset;
		@(posedge clk_sys) disable iff (1'b0) rst |=> !lock_r && params_r == RST_PARAMS && perp_r == RST_PERP;
	endproperty
	a_hw_reset: assert property (p_hw_reset) else $error("hw reset left state");

	sequence s_lock_cmd;
		cmd_wr && cmd_op == CMD_LOCK;
	endsequence
	property p_lock_result;
		s_lock_cmd |=> res_valid && res_byte[LOCK_RES_BIT] == $past(pwdata[CMD_LOCK_BIT])
			&& lock_r == $past(pwdata[CMD_LOCK_BIT]);
	endproperty
	a_lock_result: assert property (p_lock_result) else $error("lock result wrong");

	property p_dump_lock_byte;
		res_valid && res_idx == 4'h7 && $past(res_idx) == 4'h6 |-> res_byte == {lock_r, 1'b0, perp_r};
	endproperty
	a_dump_lock_byte: assert property (p_dump_lock_byte) else $error("dump byte eight wrong");

	property p_compat;
		global_r[GLB_IDENT_BIT] |-> compat_mode == COMPAT_MODE_A;
	endproperty
	a_compat: assert property (p_compat) else $error("compat mode wrong");

	property p_inactive_float;
		!activate_r || !powered |-> &std_pins_oe_n && &pp_pins_oe_n;
	endproperty
	a_inactive_float: assert property (p_inactive_float) else $error("pins driven while off");

	property p_bit7_std_only;
		dev_on && mode_r[MODE_OUTCTL_BIT] |-> &std_pins_oe_n && pp_pins_oe_n == '0;
	endproperty
	a_bit7_std_only: assert property (p_bit7_std_only) else $error("bit 7 pin split wrong");

	property p_base_invalid;
		!base_ok |-> &std_pins_oe_n;
	endproperty
	a_base_invalid: assert property (p_base_invalid) else $error("pins driven with bad base");

	property p_manual_pd;
		pwrdn_r |-> &std_pins_oe_n && &pp_pins_oe_n;
	endproperty
	a_manual_pd: assert property (p_manual_pd) else $error("manual power-down ignored");

	property p_auto_partial;
		activate_r && base_ok && powered && !pwrdn_r && !mode_r[MODE_OUTCTL_BIT] && !(&auto_pd_conds)
			|-> std_pins_oe_n == '0;
	endproperty
	a_auto_partial: assert property (p_auto_partial) else $error("floated on partial auto");

	property p_pin_data;
		1'b1 |=> std_pins_o == $past(core_pins);
	endproperty
	a_pin_data: assert property (p_pin_data) else $error("pin data not passed");

	property p_soft_perp;
		soft_rst |=> !perp_r.gap && !perp_r.perp_write_gate_bit && perp_r.drive_perp == $past(perp_r.drive_perp);
	endproperty
	a_soft_perp: assert property (p_soft_perp) else $error("soft reset perp bits wrong");
endmodule

// ---- fdc_lock_pkg.sv ----
/*
 floppy lock / pin tri-state package: register map, field positions,
 reset values, command codes and carrier types.
 assumes a 32-bit apb slave with byte addresses in paddr[7:0].
*/
package fdc_lock_pkg;
	// ---------------------------------------------------------------
	// register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_ACTIVATE = 8'h00;
	localparam logic [7:0] OFS_BASE = 8'h04;
	localparam logic [7:0] OFS_GLOBAL = 8'h08;
	localparam logic [7:0] OFS_MODE = 8'h0c;
	localparam logic [7:0] OFS_DATA_RATE = 8'h10;
	localparam logic [7:0] OFS_DIGITAL_OUT = 8'h14;
	localparam logic [7:0] OFS_COMMAND = 8'h18;
	localparam logic [7:0] OFS_RESULT = 8'h1c;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_PARAMS = 8'h24;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int ACT_BIT = 0;
	localparam int GLB_POWER_BIT = 0;
	localparam int GLB_AUTOPM_BIT = 8;
	localparam int GLB_IDENT_BIT = 16;
	localparam int GLB_MODSEL_BIT = 17;
	localparam int MODE_OUTCTL_BIT = 7;
	localparam int DR_SWRST_BIT = 7;
	localparam int DR_PWRDN_BIT = 6;
	localparam int DO_RESET_N_BIT = 2;
	localparam int CMD_LOCK_BIT = 7;
	localparam int CMD_FIFO_EN_BIT = 8;
	localparam int CMD_THR_LSB = 12;
	localparam int CMD_PRECOMP_START_TRACK_LSB = 16;
	localparam int CMD_GAP_BIT = 8;
	localparam int CMD_PERP_WRITE_GATE_BIT_BIT = 9;
	localparam int CMD_DRV_LSB = 10;
	localparam int CMD_OW_BIT = 14;
	localparam int LOCK_RES_BIT = 4;
	localparam int RES_VALID_BIT = 8;
	// ---------------------------------------------------------------
	// command codes and result layout
	// ---------------------------------------------------------------
	localparam logic [2:0] CMD_CONFIGURE = 3'h1;
	localparam logic [2:0] CMD_LOCK = 3'h2;
	localparam logic [2:0] CMD_PERP = 3'h3;
	localparam logic [2:0] CMD_DUMP = 3'h4;
	localparam int DUMP_LEN = 10;
	localparam logic [3:0] DUMP_LEN_W = 4'ha;
	localparam logic [3:0] LOCK_LEN_W = 4'h1;
	localparam int DUMP_LOCK_IDX = 7;
	localparam int DUMP_CFG_IDX = 8;
	localparam int DUMP_PRECOMP_START_TRACK_IDX = 9;
	// ---------------------------------------------------------------
	// base window and reset values
	// ---------------------------------------------------------------
	localparam logic [15:0] BASE_MIN = 16'h0100;
	localparam logic [15:0] BASE_MAX = 16'h0ff8;
	localparam logic [15:0] RST_BASE = 16'h0000;
	localparam logic RST_ACTIVATE = 1'b0;
	localparam logic [31:0] RST_GLOBAL = 32'h0000_0001;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic RST_PWRDN = 1'b0;
	localparam logic RST_LOCK = 1'b0;
	localparam int PIN_W = 10;
	localparam logic [PIN_W-1:0] RST_PIN_DATA = 10'h3ff;

	typedef struct packed {
		logic fifo_enable_param;
		logic [3:0] fifo_threshold_param;
		logic [7:0] precomp_start_track;
	} lock_params_s;
	localparam lock_params_s RST_PARAMS = '{1'b0, 4'h0, 8'h00};

	typedef struct packed {
		logic [3:0] drive_perp;
		logic gap;
		logic perp_write_gate_bit;
	} perp_s;
	localparam perp_s RST_PERP = '{4'h0, 1'b0, 1'b0};

	// active-low drive pins in the order they leave the block
	typedef struct packed {
		logic write_data_out;
		logic drive_density_out;
		logic head_select_out;
		logic write_gate_out;
		logic step_direction_out;
		logic step_pulse_out;
		logic drive_select_a;
		logic drive_select_b;
		logic motor_enable_a;
		logic motor_enable_b;
	} floppy_pins_s;

	typedef enum logic [2:0] {
		COMPAT_MODE_A = 3'b001,
		COMPAT_MODE_B = 3'b010,
		COMPAT_MODE_C = 3'b100
	} compat_mode_e;

	typedef enum logic [1:0] {
		RS_IDLE = 2'b01,
		RS_SEND = 2'b10
	} result_state_e;
endpackage

// ---- pin_gate.sv ----
/*
 one group of floppy output pins: registered data and an active-low
 output enable.
 assumes the pad or bench resolves the wire from data and enable.
*/
`timescale 1ns/1ps
module pin_gate
	import fdc_lock_pkg::*;
#(
	parameter int W = PIN_W
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [W-1:0] din,
	input wire logic drive,
	output logic [W-1:0] dout,
	output logic [W-1:0] oe_n
);
	// ---------------------------------------------------------------
	// data register and enable
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dout <= RST_PIN_DATA[W-1:0];
		end else begin
			dout <= din;
		end
	end

	// enable stays combinational so a power or activate change acts at once
	assign oe_n = {W{~drive}};
endmodule

// ---- result_seq.sv ----
/*
 result byte sequencer: holds up to ten result bytes and hands them out
 one per pop.
 assumes load, pop and flush are one-cycle pulses from the register side.
*/
`timescale 1ns/1ps
module result_seq
	import fdc_lock_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic flush,
	input wire logic load,
	input wire logic [3:0] len,
	input wire logic [DUMP_LEN*8-1:0] bytes_in,
	input wire logic pop,
	output logic [7:0] byte_o,
	output logic [3:0] idx,
	output logic valid
);
	result_state_e state_r;
	logic [7:0] mem [0:DUMP_LEN-1];
	logic [3:0] len_r;

	// ---------------------------------------------------------------
	// sequencing
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst || flush) begin
			state_r <= RS_IDLE;
			idx <= 4'h0;
			len_r <= 4'h0;
		end else begin
			case (state_r)
				RS_IDLE: begin
					if (load) begin
						state_r <= RS_SEND;
						idx <= 4'h0;
						len_r <= len;
					end
				end
				RS_SEND: begin
					// a fresh command drops whatever was left unread
					if (load) begin
						idx <= 4'h0;
						len_r <= len;
					end else if (pop) begin
						if (idx == len_r - 4'h1) begin
							state_r <= RS_IDLE;
						end
						idx <= idx + 4'h1;
					end
				end
				default: state_r <= RS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (load) begin
			for (int i = 0; i < DUMP_LEN; i++) begin
				mem[i] <= bytes_in[i*8 +: 8];
			end
		end
	end

	assign valid = (state_r == RS_SEND);
	assign byte_o = valid ? mem[idx] : 8'h00;
endmodule

// ---- floppy_drive_model.sv ----
/*
 floppy drive side of the pin interface: resolves each pin wire.
 assumes drive terminators pull every released line high.
*/
`timescale 1ns/1ps
module floppy_drive_model
	import fdc_lock_pkg::*;
(
	input wire floppy_pins_s std_pins_o,
	input wire floppy_pins_s std_pins_oe_n,
	input wire floppy_pins_s pp_pins_o,
	input wire floppy_pins_s pp_pins_oe_n,
	output floppy_pins_s std_wire,
	output floppy_pins_s pp_wire
);
	// ---------------------------------------------------------------
	// wire resolution
	// ---------------------------------------------------------------
	// a floated line reads as the terminator level, never the last value
	assign std_wire = (std_pins_o | std_pins_oe_n);
	assign pp_wire = (pp_pins_o | pp_pins_oe_n);
endmodule

// ---- floppy_lock_and_pin_tristate_bench.sv ----
/*
 self-checking bench: apb master, pin stimulus, read result queue.
 assumes zero or more wait states and a pulled-up drive cable.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module floppy_lock_and_pin_tristate_bench
	import fdc_lock_pkg::*;
;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	floppy_pins_s core_pins = '0, pp_core_pins = '0, std_pins_o, std_pins_oe_n, pp_pins_o, pp_pins_oe_n;
	floppy_pins_s std_wire, pp_wire;
	logic [3:0] auto_pd_conds = 4'he;
	compat_mode_e compat_mode;
	integer seed = 74, errors = 0, checks_done = 0;
	logic [32:0] exp_q[$], mask_q[$];
	always #5 clk_sys = ~clk_sys;

	floppy_lock_and_pin_tristate uut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .core_pins(core_pins), .pp_core_pins(pp_core_pins),
		.auto_pd_conds(auto_pd_conds), .std_pins_o(std_pins_o), .std_pins_oe_n(std_pins_oe_n),
		.pp_pins_o(pp_pins_o), .pp_pins_oe_n(pp_pins_oe_n), .compat_mode(compat_mode));
	floppy_drive_model drive (.std_pins_o(std_pins_o), .std_pins_oe_n(std_pins_oe_n),
		.pp_pins_o(pp_pins_o), .pp_pins_oe_n(pp_pins_oe_n), .std_wire(std_wire), .pp_wire(pp_wire));

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task complete_run;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// request held until pready is seen high at a rising edge
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		integer n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
			complete_run;
		end else begin
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	// expected {pslverr, prdata} noted before the read is issued
	task rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
		exp_q.push_back(e);
		mask_q.push_back(m);
		apb(1'b0, a, 32'h0000_0000);
	endtask

	task pins(input logic s, input logic p);
		floppy_pins_s r;
		r = 10'($random(seed));
		@(posedge clk_sys);
		core_pins <= r; pp_core_pins <= ~r;
		@(posedge clk_sys);
		#1;
		`CHK("std_oe_n", {10{~s}}, std_pins_oe_n)
		`CHK("pp_oe_n", {10{~p}}, pp_pins_oe_n)
		`CHK("std_wire", (s ? r : 10'h3ff), std_wire)
		`CHK("pp_wire", (p ? ~r : 10'h3ff), pp_wire)
	endtask

	task done(input string nm);
		$display("test %s finished", nm);
	endtask

	// ---------------------------------------------------------------
	// result monitor
	// ---------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (exp_q.size() == 0) begin
				errors++;
				$display("unexpected read exp none got %h", prdata);
			end else begin
				`CHK("read", exp_q[0] & mask_q[0], {pslverr, prdata} & mask_q[0])
				void'(exp_q.pop_front());
				void'(mask_q.pop_front());
			end
		end
	end

	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	logic [7:0] dump_exp[10];
	logic [31:0] glb[3];
	compat_mode_e cm[3];
	initial begin
		glb = '{32'h0001_0001, 32'h0002_0001, 32'h0000_0001};
		cm = '{COMPAT_MODE_A, COMPAT_MODE_B, COMPAT_MODE_C};
		dump_exp = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hab, 8'h25, 8'h33};
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		#1;
		`CHK("compat", COMPAT_MODE_C, compat_mode)
		rd(OFS_PARAMS, 33'h0, '1);
		rd(8'h30, 33'h1_0000_0000, '1);
		pins(1'b0, 1'b0);
		done("reset");
		for (int i = 0; i < 3; i++) begin
			wr(OFS_GLOBAL, glb[i]);
			#1;
			`CHK("compat", cm[i], compat_mode)
		end
		done("compat");
		wr(OFS_BASE, 32'h100); wr(OFS_ACTIVATE, 32'h1); pins(1'b1, 1'b1);
		wr(OFS_BASE, 32'hff); pins(1'b0, 1'b0);
		wr(OFS_BASE, 32'hff8); pins(1'b1, 1'b1);
		wr(OFS_BASE, 32'hff9); pins(1'b0, 1'b0);
		wr(OFS_BASE, 32'h100);
		wr(OFS_MODE, 32'h80); pins(1'b0, 1'b1);
		wr(OFS_MODE, 32'h0);
		wr(OFS_GLOBAL, 32'h0); pins(1'b0, 1'b0);
		wr(OFS_GLOBAL, 32'h101); pins(1'b1, 1'b1);
		auto_pd_conds <= 4'hf; pins(1'b0, 1'b0);
		auto_pd_conds <= 4'he;
		wr(OFS_DATA_RATE, 32'h40); pins(1'b0, 1'b0);
		wr(OFS_DATA_RATE, 32'h0); wr(OFS_GLOBAL, 32'h1); pins(1'b1, 1'b1);
		done("pins");
		wr(OFS_COMMAND, 32'h0033_5101);
		wr(OFS_COMMAND, 32'h82);
		rd(OFS_RESULT, 33'h110, 33'h1ff);
		rd(OFS_RESULT, 33'h0, 33'h100);
		wr(OFS_COMMAND, 32'h6b03);
		wr(OFS_COMMAND, 32'h4);
		for (int i = 0; i < 10; i++)
			rd(OFS_RESULT, {25'h1, dump_exp[i]}, 33'h1ff);
		done("lock_dump");
		wr(OFS_DIGITAL_OUT, 32'h0);
		rd(OFS_PARAMS, 33'h5_1533, '1);
		rd(OFS_RESULT, 33'h0, 33'h100);
		wr(OFS_COMMAND, 32'h2);
		rd(OFS_RESULT, 33'h100, 33'h1ff);
		wr(OFS_DATA_RATE, 32'h80);
		rd(OFS_PARAMS, 33'h5_0000, '1);
		done("soft_reset");
		wr(OFS_COMMAND, 32'h0033_5101);
		wr(OFS_COMMAND, 32'h82);
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		rd(OFS_PARAMS, 33'h0, '1);
		rd(OFS_STATUS, 33'h0, 33'h1);
		pins(1'b0, 1'b0);
		done("hard_reset");
		repeat (3) @(posedge clk_sys);
		if (exp_q.size() != 0) begin
			errors++;
			$display("unexpected reads_left exp 0 got %0d", exp_q.size());
		end
		complete_run;
	end

	initial begin
		#100000;
		errors++;
		complete_run;
	end
endmodule
